// [src/ssc_converter.sv]
// Purpose: slave serial/parallel converter with ADC buffer mode
// Assumes: serial clock and chip select are routed levels, synchronous
// Notes: serial clock must stay slow against clock_in for edge detection
`timescale 1ns/100ps
module ssc_converter
    import ssc_pkg::*;
#(
    parameter int BYTE_W = 8,
    parameter int WORD_W = 16
)
(
    input wire logic clock_in, // system clock, 10 MHz
    input wire logic rst_in, // async reset, high
    input wire logic [ADDR_W-1:0] reg_addr_in, // register address
    input wire logic [DATA_W-1:0] reg_wdata_in, // register write data
    input wire logic reg_wr_in, // write strobe
    input wire logic reg_rd_in, // read strobe
    output logic [DATA_W-1:0] reg_rdata_out, // read data, next cycle
    input wire logic sclk_route_in, // serial clock from routing
    input wire logic chip_select_low_in, // chip select, low active
    input wire logic sdio_in, // data pin input level
    output logic sdio_out, // data pin output level
    output logic sdio_oe_out, // data pin output enable
    input wire logic matrix_dout_in, // matrix data for the pin
    input wire logic matrix_oe_in, // matrix enable for the pin
    input wire logic adc_serial_in, // ADC serial stream
    input wire logic [BYTE_W-1:0] adc_data_in, // ADC parallel byte
    input wire logic adc_buf_clk_in, // routed ADC buffer clock
    input wire logic [BYTE_W-1:0] state_machine_a_in, // machine a byte
    input wire logic [BYTE_W-1:0] state_machine_b_in, // machine b byte
    input wire logic adc_pwm_tick_in, // ADC/PWM clock enable
    input wire logic [BYTE_W-2:0] route_alt_in, // PWM and oscillator bits
    output logic [WORD_W-1:0] parallel_out, // serial-in word
    output logic [BYTE_W-1:0] matrix_route_out, // matrix input byte
    output logic sync_out, // load in progress
    output logic adc_pwm_tick_out, // gated ADC/PWM enable
    output logic fsm_tick_out // gated machine enable, /256
);
    // widths and timing budget checked at elaboration
    if (WORD_W != 2 * BYTE_W || WORD_W > DATA_W)
        $error("word must be two bytes within the bus");
    if (SYNC_LOAD_CYCLES > CSS_CYCLES)
        $error("load does not fit the select setup time");

    function automatic logic pick_edge(input logic sel, input logic on_fall,
                                       input logic rise, input logic fall);
        pick_edge = (sel ^ on_fall) ? fall : rise;
    endfunction

    logic [DATA_W-1:0] ctrl_reg;
    ssc_state_e state_reg;
    logic [CNT_W-1:0] bit_cnt_reg;
    logic [WORD_W-1:0] shift_reg;
    logic [DIV_W-1:0] div_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [BYTE_W-1:0] route_reg;
    logic sync_reg, sdo_bit_reg, sdio_out_reg, sdio_oe_reg;
    logic adc_tick_reg, fsm_tick_reg;
    logic adc_buf_en, cpha, cpol, byte_sel, dir_p2s, route_en, p2s_adc;
    logic [1:0] sdio_sel;

    assign adc_buf_en = ctrl_reg[CTRL_ADC_BUF];
    assign cpha = ctrl_reg[CTRL_CPHA];
    assign cpol = ctrl_reg[CTRL_CPOL];
    assign byte_sel = ctrl_reg[CTRL_BYTE_SEL];
    assign dir_p2s = ctrl_reg[CTRL_DIR];
    assign route_en = ctrl_reg[CTRL_ROUTE];
    assign sdio_sel = ctrl_reg[CTRL_SDIO_LO +: 2];
    assign p2s_adc = ctrl_reg[CTRL_P2S_ADC];

    logic [1:0] rise, fall;
    logic sclk_lead, sclk_trail, sample_edge, change_edge, adc_clk_rise;
    // serial clock and ADC buffer clock come from the routing matrix
    ssc_edge_det #(.WIDTH(2)) u_edges
    (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .level_in({adc_buf_clk_in, sclk_route_in}),
        .rise_out(rise),
        .fall_out(fall)
    );

    // idle level sets which edge leads
    assign sclk_lead = pick_edge(cpol, 1'b0, rise[0], fall[0]);
    assign sclk_trail = pick_edge(cpol, 1'b1, rise[0], fall[0]);
    assign sample_edge = cpha ? sclk_trail : sclk_lead;
    assign change_edge = cpha ? sclk_lead : sclk_trail;
    assign adc_clk_rise = rise[1];

    logic shifting, p2s_active, count_edge, word_done;
    logic [CNT_W-1:0] last_bit;
    logic [WORD_W-1:0] shifted, load_word;

    assign shifting = (state_reg == SSC_SHIFT) && !chip_select_low_in;
    assign p2s_active = dir_p2s && cpha;
    assign count_edge = dir_p2s ? change_edge : sample_edge;
    assign last_bit = byte_sel ? CNT_W'(BYTE_W - 1)
                               : CNT_W'(WORD_W - 1);
    assign word_done = shifting && !dir_p2s && sample_edge
                       && (bit_cnt_reg == last_bit);
    assign shifted = {shift_reg[WORD_W-2:0], sdio_in};

    // eight-bit source is machine b or the ADC; sixteen packs a over b
    always_comb
    begin
        load_word = {state_machine_a_in, state_machine_b_in};
        if (byte_sel)
            load_word = {{BYTE_W{1'b0}},
                         p2s_adc ? adc_data_in : state_machine_b_in};
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            ctrl_reg <= CTRL_RESET;
        else if (reg_wr_in && reg_addr_in == OFS_CTRL)
            ctrl_reg <= reg_wdata_in & DATA_W'((1 << CTRL_USED_W) - 1);
    end

    // select high forces idle from any state
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            state_reg <= SSC_IDLE;
        else if (chip_select_low_in)
            state_reg <= SSC_IDLE;
        else
        begin
            case (state_reg)
                SSC_IDLE:
                    state_reg <= p2s_active ? SSC_SYNC : SSC_SHIFT;
                SSC_SYNC:
                    state_reg <= SSC_LOAD;
                SSC_LOAD:
                    state_reg <= SSC_SHIFT;
                SSC_SHIFT:
                    state_reg <= SSC_SHIFT;
                default:
                    state_reg <= SSC_IDLE;
            endcase
        end
    end

    // sync spans the sync and load states so the captured word is stable
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            sync_reg <= 1'b0;
        else
            sync_reg <= !chip_select_low_in
                        && ((state_reg == SSC_IDLE && p2s_active)
                            || state_reg == SSC_SYNC);
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            bit_cnt_reg <= '0;
        else if (chip_select_low_in || !shifting)
            bit_cnt_reg <= '0;
        else if (count_edge)
            bit_cnt_reg <= (bit_cnt_reg == last_bit) ? '0
                           : bit_cnt_reg + CNT_W'(1);
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            shift_reg <= '0;
        else if (state_reg == SSC_LOAD)
            shift_reg <= load_word;
        else if (shifting && !dir_p2s && sample_edge)
            shift_reg <= shifted;
        else if (shifting && p2s_active && change_edge)
            shift_reg <= {shift_reg[WORD_W-2:0], 1'b0};
    end

    // most significant bit goes first, low byte msb in eight-bit mode
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            sdo_bit_reg <= 1'b0;
        else if (state_reg != SSC_SHIFT)
            sdo_bit_reg <= 1'b0;
        else if (p2s_active && change_edge)
            sdo_bit_reg <= byte_sel ? shift_reg[BYTE_W-1]
                                    : shift_reg[WORD_W-1];
    end

    logic [1:0] hold_load;
    logic [WORD_W-1:0] hold_data;

    // ADC buffer mode takes the low byte away from the serial path
    assign hold_load[1] = word_done && !byte_sel;
    assign hold_load[0] = adc_buf_en ? adc_clk_rise : word_done;
    assign hold_data[WORD_W-1:BYTE_W] = shifted[WORD_W-1:BYTE_W];
    assign hold_data[BYTE_W-1:0] = adc_buf_en ? adc_data_in
                                              : shifted[BYTE_W-1:0];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_hold
            ssc_hold_byte #(.BYTE_W(BYTE_W)) u_hold
            (
                .clock_in(clock_in),
                .rst_in(rst_in),
                .load_in(hold_load[gi]),
                .data_in(hold_data[gi*BYTE_W +: BYTE_W]),
                .q_out(parallel_out[gi*BYTE_W +: BYTE_W])
            );
        end
    endgenerate

    // pin driver; serial output only while a phase-one unload runs
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sdio_out_reg <= 1'b0;
            sdio_oe_reg <= 1'b0;
        end
        else
        begin
            case (sdio_sel)
                SDIO_SEL_SPI:
                begin
                    sdio_out_reg <= sdo_bit_reg;
                    sdio_oe_reg <= shifting && p2s_active;
                end
                SDIO_SEL_ADC:
                begin
                    sdio_out_reg <= adc_serial_in;
                    sdio_oe_reg <= 1'b1;
                end
                default:
                begin
                    sdio_out_reg <= matrix_dout_in;
                    sdio_oe_reg <= matrix_oe_in;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            route_reg <= '0;
        else if (route_en)
            route_reg <= parallel_out[BYTE_W-1:0];
        else
            route_reg <= {1'b0, route_alt_in};
    end

    // divider keeps running; only its pulse is withheld during sync
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            div_reg <= '0;
        else
            div_reg <= div_reg + DIV_W'(1);
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            fsm_tick_reg <= 1'b0;
            adc_tick_reg <= 1'b0;
        end
        else
        begin
            fsm_tick_reg <= (div_reg == '1) && !sync_reg;
            adc_tick_reg <= adc_pwm_tick_in && !sync_reg;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            rdata_reg <= '0;
        else if (!reg_rd_in)
            rdata_reg <= '0;
        else
        begin
            case (reg_addr_in)
                OFS_CTRL:
                    rdata_reg <= ctrl_reg;
                OFS_STATUS:
                begin
                    rdata_reg <= '0;
                    rdata_reg[STAT_BUSY] <= state_reg != SSC_IDLE;
                    rdata_reg[STAT_SYNC] <= sync_reg;
                    rdata_reg[STAT_STATE_LO +: 4] <= state_reg;
                    rdata_reg[STAT_CNT_LO +: CNT_W] <= bit_cnt_reg;
                end
                OFS_PAR:
                    rdata_reg <= DATA_W'(parallel_out);
                OFS_SHIFT:
                    rdata_reg <= DATA_W'(shift_reg);
                default:
                    rdata_reg <= '0;
            endcase
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign sdio_out = sdio_out_reg;
    assign sdio_oe_out = sdio_oe_reg;
    assign matrix_route_out = route_reg;
    assign sync_out = sync_reg;
    assign fsm_tick_out = fsm_tick_reg;
    assign adc_pwm_tick_out = adc_tick_reg;

    AST_CS_RELEASE:
    assert property (@(posedge clock_in) disable iff (rst_in)
        (chip_select_low_in && sdio_sel == SDIO_SEL_SPI)
        |=> !sdio_oe_out ##1 (bit_cnt_reg == '0))
    else $error("select high left output driven or count set");

    AST_CPHA0_NO_OUT:
    assert property (@(posedge clock_in) disable iff (rst_in)
        (!cpha && sdio_sel == SDIO_SEL_SPI) |=> !sdio_oe_out)
    else $error("serial output driven at phase zero");

    AST_SYNC_LOAD:
    assert property (@(posedge clock_in) disable iff (rst_in)
        (state_reg == SSC_IDLE && !chip_select_low_in && p2s_active)
        |=> sync_reg ##1 (sync_reg && state_reg == SSC_LOAD))
    else $error("sync missing around parallel load");

    AST_TICK_GATED:
    assert property (@(posedge clock_in) disable iff (rst_in)
        sync_reg |=> !fsm_tick_out && !adc_pwm_tick_out)
    else $error("tick passed during sync");

    AST_ADC_BUF:
    assert property (@(posedge clock_in) disable iff (rst_in)
        (adc_buf_en && adc_clk_rise)
        |=> parallel_out[BYTE_W-1:0] == $past(adc_data_in))
    else $error("ADC byte not buffered one clock later");

    AST_ROUTE:
    assert property (@(posedge clock_in) disable iff (rst_in)
        route_en |=> matrix_route_out == $past(parallel_out[BYTE_W-1:0]))
    else $error("low byte not routed to matrix");

    AST_ADC_PIN:
    assert property (@(posedge clock_in) disable iff (rst_in)
        (sdio_sel == SDIO_SEL_ADC)
        |=> sdio_oe_out && sdio_out == $past(adc_serial_in))
    else $error("ADC serial not on pin");

    AST_WORD16:
    assert property (@(posedge clock_in) disable iff (rst_in)
        (word_done && !byte_sel && !adc_buf_en)
        |=> parallel_out == $past(shifted))
    else $error("sixteen-bit word not presented");

    AST_LOAD16:
    assert property (@(posedge clock_in) disable iff (rst_in)
        (state_reg == SSC_LOAD && !byte_sel)
        |=> shift_reg == $past({state_machine_a_in, state_machine_b_in}))
    else $error("sixteen-bit load order wrong");
endmodule

// [src/ssc_edge_det.sv]
// Purpose: rise and fall detection on synchronous level inputs
// Assumes: inputs already synchronous to clock_in
// Notes: edges come out combinationally, in the same cycle as the level changes
`timescale 1ns/100ps
module ssc_edge_det
#(
    parameter int WIDTH = 2
)
(
    input wire logic clock_in, // system clock
    input wire logic rst_in, // async reset, high
    input wire logic [WIDTH-1:0] level_in, // sampled levels
    output logic [WIDTH-1:0] rise_out, // low to high seen
    output logic [WIDTH-1:0] fall_out // high to low seen
);
    logic [WIDTH-1:0] prev_reg;

    if (WIDTH < 1)
        $error("edge detector needs at least one input");

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            prev_reg <= '0;
        else
            prev_reg <= level_in;
    end

    assign rise_out = level_in & ~prev_reg;
    assign fall_out = ~level_in & prev_reg;
endmodule

// [src/ssc_hold_byte.sv]
// Purpose: one byte-wide parallel holding register
// Assumes: load is a one-cycle enable
// Notes: two of these make the sixteen-bit parallel output
`timescale 1ns/100ps
module ssc_hold_byte
#(
    parameter int BYTE_W = 8
)
(
    input wire logic clock_in, // system clock
    input wire logic rst_in, // async reset, high
    input wire logic load_in, // capture enable
    input wire logic [BYTE_W-1:0] data_in, // byte to capture
    output logic [BYTE_W-1:0] q_out // held byte
);
    if (BYTE_W < 1)
        $error("holding register needs at least one bit");

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            q_out <= '0;
        else if (load_in)
            q_out <= data_in;
    end
endmodule

// [src/ssc_pkg.sv]
// Purpose: shared constants and types of the slave serial/parallel converter
// Assumes: one 10 MHz clock, all pins synchronous to it
// Notes: register map, control field positions, timing budget, state codes
// Behaviour
// - transfer data sits in two byte-wide holding registers, sixteen bits
// - serial-in word appears as 16 bits: high byte and low byte outputs
// - parallel-in serial-out length is configurable, eight or sixteen bits
// - eight-bit length shifts out a byte from state machine b or ADC
// - sixteen-bit length loads b into bits 7..0, a into 15..8, shifts all
// - clock phase zero allows only serial-in, never drives serial output
// - clock phase one allows both serial-in and parallel-in serial-out
// - serial clock idles low at polarity zero, high at polarity one
// - phase zero samples leading edge; phase one samples trailing edge
// - sync is raised around a parallel load, pausing ADC/PWM and /256 ticks
// - ADC buffer mode clocks ADC data into low outputs from a routed clock
// - buffered ADC byte appears on low outputs one clock after capture
// - byte select: zero gives sixteen bits, one gives low eight bits
// - direction select: zero serial-in parallel-out, one parallel-in out
// - route bit one puts low output byte onto eight matrix inputs
// - pin selector: 0x matrix, 10 serial output, 11 ADC serial output
// - clock phase and polarity each have their own adjacent control bit
// - one pin carries serial input or serial output depending on mode
// - serial clock and chip select arrive from routing, not pins
package ssc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int CNT_W = 5;

    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_PAR = 4'h2;
    localparam logic [3:0] OFS_SHIFT = 4'h3;

    localparam int CTRL_ADC_BUF = 0;
    localparam int CTRL_CPHA = 1;
    localparam int CTRL_CPOL = 2;
    localparam int CTRL_BYTE_SEL = 3;
    localparam int CTRL_DIR = 4;
    localparam int CTRL_ROUTE = 5;
    localparam int CTRL_SDIO_LO = 6;
    localparam int CTRL_P2S_ADC = 8;
    localparam int CTRL_USED_W = 9;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

    localparam int STAT_BUSY = 0;
    localparam int STAT_SYNC = 1;
    localparam int STAT_STATE_LO = 2;
    localparam int STAT_CNT_LO = 6;

    localparam logic [1:0] SDIO_SEL_SPI = 2'b10;
    localparam logic [1:0] SDIO_SEL_ADC = 2'b11;

    localparam int CLK_PERIOD_NS = 100;
    localparam int CSS_MIN_NS = 250;
    localparam int CSS_CYCLES = CSS_MIN_NS / CLK_PERIOD_NS;
    localparam int SYNC_LOAD_CYCLES = 2;
    localparam int FSM_DIV = 256;
    localparam int DIV_W = $clog2(FSM_DIV);

    typedef enum logic [3:0] {
        SSC_IDLE = 4'b0001,
        SSC_SYNC = 4'b0010,
        SSC_LOAD = 4'b0100,
        SSC_SHIFT = 4'b1000
    } ssc_state_e;
endpackage

// [test/ssc_converter_bench.sv]
// Purpose: self-checking bench of the serial/parallel converter
// Assumes: 10 MHz clock, master half period of four clocks
// Notes: outputs are read right after an edge, before its updates land
`timescale 1ns/100ps
module slave_spi_serial_parallel_converter_bench;
    import ssc_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] addr = '0;
    logic [15:0] wdata = '0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [15:0] rdata, par, rx, d, model_par;
    logic sclk, cs_low, mosi, sdio, sdo, sdo_oe, sync, tick_out, fsm_tick;
    logic mx_dout = 1'b0, mx_oe = 1'b0, adc_ser = 1'b0, buf_clk = 1'b0;
    logic [7:0] adc_b = '0, sm_a = '0, sm_b = '0, route;
    logic tick_in = 1'b0, prev_in = 1'b0, prev_sync = 1'b0;
    logic [6:0] alt = '0;
    int n_mismatch = 0, checked = 0, cycles = 0, seed, s0, o0;
    int n_sync = 0, n_oe = 0, n_fsm = 0;
    always #50 clock_in = ~clock_in;
    // the pin resolves to whoever enables it; the master fills the gaps
    assign sdio = sdo_oe ? sdo : mosi;
    ssc_converter DUT (.clock_in(clock_in), .rst_in(rst_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
        .reg_rd_in(rd_s), .reg_rdata_out(rdata), .sclk_route_in(sclk),
        .chip_select_low_in(cs_low), .sdio_in(sdio), .sdio_out(sdo),
        .sdio_oe_out(sdo_oe), .matrix_dout_in(mx_dout),
        .matrix_oe_in(mx_oe), .adc_serial_in(adc_ser), .adc_data_in(adc_b),
        .adc_buf_clk_in(buf_clk), .state_machine_a_in(sm_a),
        .state_machine_b_in(sm_b), .adc_pwm_tick_in(tick_in),
        .route_alt_in(alt), .parallel_out(par), .matrix_route_out(route),
        .sync_out(sync), .adc_pwm_tick_out(tick_out),
        .fsm_tick_out(fsm_tick));
    ssc_spi_master master (.clock_in(clock_in), .sdio_in(sdio),
        .sclk_out(sclk), .chip_select_low_out(cs_low), .mosi_out(mosi));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("counts: checked=%0d mismatches=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clock_in)
    begin
        cycles <= cycles + 1;
        tick_in <= 1'($urandom);
        prev_in <= tick_in;
        prev_sync <= sync;
        n_sync <= n_sync + int'(sync);
        n_oe <= n_oe + int'(sdo_oe);
        n_fsm <= n_fsm + int'(fsm_tick);
        if (cycles > 18 && !sync && !prev_sync)
            chk(16'(tick_out), 16'(prev_in));
        if (sync && prev_sync)
            chk({14'h0, fsm_tick, tick_out}, 16'h0000);
        if (cycles == 20000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        wait_clk(1);
        wr_s <= 1'b0;
        wait_clk(1);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        addr <= a;
        rd_s <= 1'b1;
        wait_clk(1);
        rd_s <= 1'b0;
        wait_clk(1);
        v = rdata;
    endtask
    function automatic logic [15:0] ctl(input int pol, pha, bs, dir, sel);
        ctl = 16'((pol << CTRL_CPOL) | (pha << CTRL_CPHA) | (dir << CTRL_DIR)
            | (bs << CTRL_BYTE_SEL) | (sel << CTRL_SDIO_LO));
    endfunction
    task automatic s2p(input int pol, input int pha, input int n);
        logic [15:0] mask;
        mask = (n == 16) ? 16'hffff : 16'h00ff;
        d = 16'($urandom);
        wr(OFS_CTRL, ctl(pol, pha, int'(n == 8), 0, 0));
        s0 = n_sync;
        master.xfer(pol, pha, n, d, rx);
        chk(par & mask, d & mask);
        chk(16'(n_sync - s0), 16'h0000);
        rd(OFS_PAR, rx);
        chk(rx & mask, d & mask);
        model_par = (n == 16) ? d : {model_par[15:8], d[7:0]};
        $display("test serial-in pol=%0d pha=%0d n=%0d done", pol, pha, n);
    endtask
    task automatic p2s(input int pol, pha, n, src);
        logic [15:0] e;
        sm_a <= 8'($urandom);
        sm_b <= 8'($urandom);
        adc_b <= 8'($urandom);
        wr(OFS_CTRL, ctl(pol, pha, int'(n == 8), 1, int'(SDIO_SEL_SPI))
            | 16'(src << CTRL_P2S_ADC));
        e = (n == 16) ? {sm_a, sm_b} : {8'h00, (src != 0) ? adc_b : sm_b};
        s0 = n_sync;
        o0 = n_oe;
        master.xfer(pol, pha, n, 16'($urandom), rx);
        if (pha != 0)
        begin
            chk(rx, e);
            chk(16'(n_sync - s0), 16'(SYNC_LOAD_CYCLES));
        end
        else
        begin
            chk(16'(n_oe - o0), 16'h0000);
            chk(16'(n_sync - s0), 16'h0000);
        end
        chk(16'(sdo_oe), 16'h0000);
        $display("test parallel-in pol=%0d pha=%0d n=%0d done", pol, pha, n);
    endtask
    initial
    begin
        seed = $urandom(32'h0558);
        wait_clk(16);
        rst_in <= 1'b0;
        wait_clk(1);
        rd(OFS_STATUS, d);
        chk(d, 16'(1 << STAT_STATE_LO));
        wr(OFS_CTRL, 16'hffff);
        rd(OFS_CTRL, d);
        chk(d, 16'((1 << CTRL_USED_W) - 1));
        wr(OFS_CTRL, 16'h0000);
        wr(OFS_STATUS, 16'hffff);
        rd(OFS_STATUS, d);
        chk(d, 16'(1 << STAT_STATE_LO));
        rd(4'h9, d);
        chk(d, 16'h0000);
        $display("test registers done");
        for (int k = 0; k < 4; k++)
            s2p(k / 2, k % 2, 16);
        s2p(1, 1, 8);
        master.xfer(1, 1, 5, 16'($urandom), rx);
        chk(par, model_par);
        $display("test cut word done");
        s2p(0, 0, 16);
        p2s(0, 1, 16, 0);
        p2s(1, 1, 16, 0);
        p2s(0, 1, 8, 0);
        p2s(1, 1, 8, 1);
        p2s(0, 0, 16, 0);
        for (int k = 0; k < 4; k++)
        begin
            mx_dout <= 1'($urandom);
            mx_oe <= 1'($urandom);
            adc_ser <= 1'($urandom);
            wr(OFS_CTRL, ctl(0, 1, 0, 0, (k == 0) ? 0 : (k == 1) ? 1 : 3));
            wait_clk(2);
            chk(16'(sdo), 16'((k < 2) ? mx_dout : adc_ser));
            if (k < 2)
                chk(16'(sdo_oe), 16'(mx_oe));
            else
                chk(16'(sdo_oe), 16'h0001);
        end
        mx_oe <= 1'b0;
        $display("test pin selector done");
        adc_b <= 8'($urandom);
        alt <= 7'($urandom);
        wr(OFS_CTRL, 16'((1 << CTRL_ADC_BUF) | (1 << CTRL_ROUTE)));
        buf_clk <= 1'b1;
        wait_clk(3);
        buf_clk <= 1'b0;
        wait_clk(3);
        chk({8'h00, par[7:0]}, {8'h00, adc_b});
        chk({8'h00, route}, {8'h00, adc_b});
        wr(OFS_CTRL, 16'h0000);
        wait_clk(2);
        chk({8'h00, route}, {9'h000, alt});
        $display("test buffer and route done");
        s0 = n_fsm;
        wait_clk(4 * FSM_DIV);
        chk(16'(n_fsm - s0), 16'h0004);
        $display("test divided tick done");
        print_verdict();
    end
endmodule

// [test/ssc_spi_master.sv]
// Purpose: behavioural serial master that faces the converter
// Assumes: half serial period of four system clocks
// Notes: data line shows the inverse of its last bit while deselected
`timescale 1ns/100ps
module ssc_spi_master
(
    input wire logic clock_in, // system clock
    input wire logic sdio_in, // resolved data pin
    output logic sclk_out, // serial clock
    output logic chip_select_low_out, // chip select, low active
    output logic mosi_out // master data
);
    localparam int HALF = 4;
    initial
    begin
        sclk_out = 1'b0;
        chip_select_low_out = 1'b1;
        mosi_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    // sampling at every trailing edge serves phase one readback
    task automatic xfer(input int pol, input int pha, input int n,
        input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        sclk_out <= 1'(pol);
        tick(1);
        mosi_out <= tx[n-1];
        chip_select_low_out <= 1'b0;
        tick(HALF);
        for (int i = 0; i < n; i++)
        begin
            if (pha != 0)
                mosi_out <= tx[n-1-i];
            sclk_out <= ~1'(pol);
            tick(HALF);
            rx = {rx[14:0], sdio_in};
            sclk_out <= 1'(pol);
            if (pha == 0 && i < n-1)
                mosi_out <= tx[n-2-i];
            tick(HALF);
        end
        chip_select_low_out <= 1'b1;
        mosi_out <= ~mosi_out;
        tick(HALF);
    endtask
endmodule
